// ==== core/logic_shift_bit_alu.v ====
// Logic, shift/rotate and single-bit datapath with an Avalon-MM slave
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "lsb_alu_defs.vh"

module logic_shift_bit_alu #(
    parameter DATA_W = 32,
    parameter MEM_AW = 32
) (
    input  wire              clk_sys_i,
    input  wire              rst_i,
    input  wire [4:0]        avs_address_i,
    input  wire              avs_read_i,
    input  wire              avs_write_i,
    input  wire [31:0]       avs_writedata_i,
    input  wire [3:0]        avs_byteenable_i,
    output reg  [31:0]       avs_readdata_o,
    output reg               avs_waitrequest_o,
    output reg  [MEM_AW-1:0] mem_addr_o,
    output reg               mem_read_o,
    output reg               mem_write_o,
    output reg  [7:0]        mem_wdata_o,
    input  wire [7:0]        mem_rdata_i,
    input  wire              mem_ack_i
);

// ==========================================================
// Helpers
function [31:0] size_mask;
    input [1:0] sz;
    begin
        if (sz == `SZ_BYTE)
            size_mask = 32'h0000_00ff;
        else if (sz == `SZ_WORD)
            size_mask = 32'h0000_ffff;
        else
            size_mask = 32'hffff_ffff;
    end
endfunction

function [31:0] size_top;
    input [1:0] sz;
    begin
        if (sz == `SZ_BYTE)
            size_top = 32'h0000_0080;
        else if (sz == `SZ_WORD)
            size_top = 32'h0000_8000;
        else
            size_top = 32'h8000_0000;
    end
endfunction

function [31:0] merge_be;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer k;
    begin
        merge_be = old_v;
        for (k = 0; k < 4; k = k + 1) begin
            if (be[k])
                merge_be[k*8 +: 8] = new_v[k*8 +: 8];
        end
    end
endfunction

// ==========================================================
// Opcode decoding, shared by the sequencer and the datapath
function is_bit_op;
    input [4:0] code;
    begin
        is_bit_op = (code >= `OP_BFONE);
    end
endfunction

// Ops whose bit position may only come from the immediate field
function is_inv_op;
    input [4:0] code;
    begin
        is_inv_op = (code == `OP_CANDI) || (code == `OP_CORI)
                    || (code == `OP_CXORI) || (code == `OP_IBTOC)
                    || (code == `OP_ICTOB);
    end
endfunction

// Only these ops change the operand byte, so only they write back
function rewrites_byte;
    input [4:0] code;
    begin
        rewrites_byte = (code == `OP_BFONE) || (code == `OP_BFZERO)
                        || (code == `OP_BTOGGLE) || (code == `OP_CTOB)
                        || (code == `OP_ICTOB);
    end
endfunction

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_READ = 2'h1;
localparam [1:0] ST_EXEC = 2'h2;
localparam [1:0] ST_WRITE = 2'h3;

// ==========================================================
// Registers
reg  [31:0]       dest;
reg  [31:0]       src;
reg  [12:0]       cmd;
reg  [3:0]        flags;
reg               done;
reg               refused;
reg  [MEM_AW-1:0] mem_addr;
reg  [7:0]        mem_byte;
reg  [1:0]        state;

wire busy = (state != ST_IDLE);
wire [4:0] op = cmd[`CMD_OP_MSB:`CMD_OP_LSB];
wire [1:0] size = cmd[`CMD_SIZE_MSB:`CMD_SIZE_LSB];
wire use_mem = cmd[`CMD_MEM];

// ==========================================================
// Bus handshake
wire req = avs_read_i | avs_write_i;
wire is_start = avs_write_i && (avs_address_i == `OFS_CMD)
                && avs_byteenable_i[3] && avs_writedata_i[`CMD_START];
// Start commands wait while busy so the operands cannot shift underneath
wire grant = req && avs_waitrequest_o && !(is_start && busy);
wire commit = req && !avs_waitrequest_o;
wire wr_commit = commit && avs_write_i;
// Only the low command bits are stored; start and spare bits drop out
wire [31:0] cmd_merged = merge_be({19'h0, cmd}, avs_writedata_i,
                                  avs_byteenable_i);

always @(posedge clk_sys_i) begin
    if (rst_i) begin
        avs_waitrequest_o <= 1'b1;
        avs_readdata_o <= `RST_WORD;
    end else begin
        // Answer one cycle after the request is seen, then back to wait
        if (grant)
            avs_waitrequest_o <= 1'b0;
        else
            avs_waitrequest_o <= 1'b1;
        if (grant && avs_read_i) begin
            if (avs_address_i == `OFS_DEST)
                avs_readdata_o <= dest;
            else if (avs_address_i == `OFS_SRC)
                avs_readdata_o <= src;
            else if (avs_address_i == `OFS_CMD)
                avs_readdata_o <= {19'h00000, cmd};
            else if (avs_address_i == `OFS_FLAGS)
                avs_readdata_o <= {28'h0000000, flags};
            else if (avs_address_i == `OFS_STATUS)
                avs_readdata_o <= {29'h0, refused, done, busy};
            else if (avs_address_i == `OFS_MEM_ADDR)
                avs_readdata_o <= mem_addr;
            else if (avs_address_i == `OFS_MEM_BYTE)
                avs_readdata_o <= {24'h000000, mem_byte};
            else
                avs_readdata_o <= `RST_WORD;
        end
    end
end

// ==========================================================
// Datapath
reg  [31:0] next_dest;
reg  [3:0]  next_flags;
reg  [7:0]  next_byte;
reg         bad_cmd;
reg  [31:0] a;
reg  [31:0] b;
reg  [31:0] m;
reg  [31:0] top;
reg  [31:0] r;
reg  [2:0]  bit_no;
reg  [7:0]  opnd;
reg         sel;
reg         a_msb;
reg         inv_op;

always @* begin
    m = size_mask(size);
    top = size_top(size);
    a = dest & m;
    b = (cmd[`CMD_SRC_IMM] ? src : src) & m;
    a_msb = |(a & top);
    r = a;
    next_flags = flags;
    next_dest = dest;
    bad_cmd = 1'b0;
    // Bit number from immediate field or low bits of source
    bit_no = cmd[`CMD_BIT_REG] ? src[2:0]
                               : cmd[`CMD_BITNO_MSB:`CMD_BITNO_LSB];
    opnd = use_mem ? mem_byte : dest[7:0];
    sel = opnd[bit_no];
    next_byte = opnd;
    inv_op = is_inv_op(op);
    if (inv_op && cmd[`CMD_BIT_REG]) begin
        bad_cmd = 1'b1;
    end else if (!is_bit_op(op)) begin
        case (op)
            `OP_AND:  r = a & b;
            `OP_OR:   r = a | b;
            `OP_XOR:  r = a ^ b;
            `OP_NOT:  r = ~a;
            `OP_ASL, `OP_LSL: r = a << 1;
            `OP_ASR:  r = (a >> 1) | (a_msb ? top : 32'h0);
            `OP_LSR:  r = a >> 1;
            `OP_ROL:  r = (a << 1) | {31'h0, a_msb};
            `OP_ROR:  r = (a >> 1) | (a[0] ? top : 32'h0);
            `OP_ROLC: r = (a << 1) | {31'h0, flags[`FLG_C]};
            `OP_RORC: r = (a >> 1) | (flags[`FLG_C] ? top : 32'h0);
            default:  r = a;
        endcase
        r = r & m;
        next_dest = (dest & ~m) | r;
        next_flags[`FLG_N] = |(r & top);
        next_flags[`FLG_Z] = (r == 32'h0);
        next_flags[`FLG_V] = 1'b0;
        if (op >= `OP_ASL) begin
            // Exactly one place; the bit pushed out lands in carry
            if (op == `OP_ASL || op == `OP_LSL || op == `OP_ROL
                || op == `OP_ROLC)
                next_flags[`FLG_C] = a_msb;
            else
                next_flags[`FLG_C] = a[0];
            if (op == `OP_ASL)
                next_flags[`FLG_V] = a_msb ^ (|(r & top));
        end
    end else begin
        case (op)
            `OP_BFONE:   next_byte[bit_no] = 1'b1;
            `OP_BFZERO:  next_byte[bit_no] = 1'b0;
            `OP_BTOGGLE: next_byte[bit_no] = ~sel;
            `OP_BTEST:   next_flags[`FLG_Z] = ~sel;
            `OP_CAND:    next_flags[`FLG_C] = flags[`FLG_C] & sel;
            `OP_CANDI:   next_flags[`FLG_C] = flags[`FLG_C] & ~sel;
            `OP_COR:     next_flags[`FLG_C] = flags[`FLG_C] | sel;
            `OP_CORI:    next_flags[`FLG_C] = flags[`FLG_C] | ~sel;
            `OP_CXOR:    next_flags[`FLG_C] = flags[`FLG_C] ^ sel;
            `OP_CXORI:   next_flags[`FLG_C] = flags[`FLG_C] ^ ~sel;
            `OP_BTOC:    next_flags[`FLG_C] = sel;
            `OP_IBTOC:   next_flags[`FLG_C] = ~sel;
            `OP_CTOB:    next_byte[bit_no] = flags[`FLG_C];
            `OP_ICTOB:   next_byte[bit_no] = ~flags[`FLG_C];
            default:     bad_cmd = 1'b1;
        endcase
        if (!use_mem)
            next_dest = {dest[31:8], next_byte};
    end
end

wire writes_byte = rewrites_byte(op);

// ==========================================================
// Sequencer and register writes
always @(posedge clk_sys_i) begin
    if (rst_i) begin
        state <= ST_IDLE;
        dest <= `RST_WORD;
        src <= `RST_WORD;
        cmd <= `RST_CMD;
        flags <= `RST_FLAGS;
        done <= 1'b0;
        refused <= 1'b0;
        mem_addr <= {MEM_AW{1'b0}};
        mem_byte <= 8'h00;
        mem_addr_o <= {MEM_AW{1'b0}};
        mem_read_o <= 1'b0;
        mem_write_o <= 1'b0;
        mem_wdata_o <= 8'h00;
    end else begin
        if (wr_commit) begin
            if (avs_address_i == `OFS_DEST && !busy)
                dest <= merge_be(dest, avs_writedata_i, avs_byteenable_i);
            else if (avs_address_i == `OFS_SRC && !busy)
                src <= merge_be(src, avs_writedata_i, avs_byteenable_i);
            else if (avs_address_i == `OFS_CMD && !busy)
                cmd <= cmd_merged[12:0];
            else if (avs_address_i == `OFS_FLAGS && !busy
                     && avs_byteenable_i[0])
                flags <= avs_writedata_i[3:0];
            else if (avs_address_i == `OFS_MEM_ADDR && !busy)
                mem_addr <= merge_be(mem_addr, avs_writedata_i,
                                     avs_byteenable_i);
        end
        // Write one to clear; a completion in the same cycle wins
        if (wr_commit && avs_address_i == `OFS_STATUS
            && avs_byteenable_i[0]) begin
            if (avs_writedata_i[`STS_DONE])
                done <= 1'b0;
            if (avs_writedata_i[`STS_REFUSED])
                refused <= 1'b0;
        end
        case (state)
            ST_IDLE: begin
                if (wr_commit && is_start) begin
                    done <= 1'b0;
                    if (avs_writedata_i[`CMD_MEM]
                        && is_bit_op(avs_writedata_i[4:0])) begin
                        mem_addr_o <= mem_addr;
                        mem_read_o <= 1'b1;
                        state <= ST_READ;
                    end else begin
                        state <= ST_EXEC;
                    end
                end
            end
            ST_READ: begin
                // Address and strobe hold until the memory answers
                if (mem_ack_i) begin
                    mem_read_o <= 1'b0;
                    mem_byte <= mem_rdata_i;
                    state <= ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (bad_cmd) begin
                    // Refused op leaves operand and flags as they were
                    refused <= 1'b1;
                    done <= 1'b1;
                    state <= ST_IDLE;
                end else begin
                    flags <= next_flags;
                    if (use_mem && is_bit_op(op)) begin
                        mem_byte <= next_byte;
                        if (writes_byte) begin
                            mem_wdata_o <= next_byte;
                            mem_write_o <= 1'b1;
                            state <= ST_WRITE;
                        end else begin
                            done <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end else begin
                        dest <= next_dest;
                        done <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
            end
            ST_WRITE: begin
                if (mem_ack_i) begin
                    mem_write_o <= 1'b0;
                    done <= 1'b1;
                    state <= ST_IDLE;
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end

endmodule // logic_shift_bit_alu

// ==== core/lsb_alu_defs.vh ====
// Offsets, fields, encodings and reset values of the logic/shift/bit ALU
`ifndef LSB_ALU_DEFS_VH
`define LSB_ALU_DEFS_VH

// ==========================================================
// Register byte offsets
`define OFS_DEST        5'h00
`define OFS_SRC         5'h04
`define OFS_CMD         5'h08
`define OFS_FLAGS       5'h0c
`define OFS_STATUS      5'h10
`define OFS_MEM_ADDR    5'h14
`define OFS_MEM_BYTE    5'h18

// ==========================================================
// Command register fields
`define CMD_OP_LSB      0
`define CMD_OP_MSB      4
`define CMD_SIZE_LSB    5
`define CMD_SIZE_MSB    6
`define CMD_SRC_IMM     7
`define CMD_BIT_REG     8
`define CMD_BITNO_LSB   9
`define CMD_BITNO_MSB   11
`define CMD_MEM         12
`define CMD_START       31

// ==========================================================
// Flag register bits
`define FLG_C           0
`define FLG_V           1
`define FLG_Z           2
`define FLG_N           3

// Status register bits
`define STS_BUSY        0
`define STS_DONE        1
`define STS_REFUSED     2

// ==========================================================
// Operand sizes
`define SZ_BYTE         2'h0
`define SZ_WORD         2'h1
`define SZ_LONG         2'h2

// ==========================================================
// Operation codes
`define OP_AND          5'h00
`define OP_OR           5'h01
`define OP_XOR          5'h02
`define OP_NOT          5'h03
`define OP_ASL          5'h04
`define OP_ASR          5'h05
`define OP_LSL          5'h06
`define OP_LSR          5'h07
`define OP_ROL          5'h08
`define OP_ROR          5'h09
`define OP_ROLC         5'h0a
`define OP_RORC         5'h0b
`define OP_BFONE        5'h0c
`define OP_BFZERO       5'h0d
`define OP_BTOGGLE      5'h0e
`define OP_BTEST        5'h0f
`define OP_CAND         5'h10
`define OP_CANDI        5'h11
`define OP_COR          5'h12
`define OP_CORI         5'h13
`define OP_CXOR         5'h14
`define OP_CXORI        5'h15
`define OP_BTOC         5'h16
`define OP_IBTOC        5'h17
`define OP_CTOB         5'h18
`define OP_ICTOB        5'h19

// ==========================================================
// Reset values
`define RST_WORD        32'h0000_0000
`define RST_FLAGS       4'h0
`define RST_CMD         13'h0000

`endif

// ==== bench/alu_mem_model.sv ====
// Byte memory model answering the datapath's memory-operand requests
`timescale 1ns/10ps
module alu_mem_model (
    input  wire        clk_sys_i,
    input  wire [31:0] addr_i,
    input  wire        rd_i,
    input  wire        wr_i,
    input  wire [7:0]  wdata_i,
    input  wire [3:0]  lat_i,
    output logic [7:0] rdata_o,
    output logic       ack_o
);
    logic [7:0] mem [0:255];
    int         cnt = 0;
    int         n_wr = 0;
    initial ack_o = 1'b0;
    initial rdata_o = 8'h00;
    // Stale read data keep changing so a late sample cannot pass
    always @(posedge clk_sys_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if ((rd_i || wr_i) && !ack_o) begin
            cnt <= cnt + 1;
            if (cnt >= lat_i) begin
                cnt <= 0;
                ack_o <= 1'b1;
                rdata_o <= mem[addr_i[7:0]];
                if (wr_i) begin
                    mem[addr_i[7:0]] <= wdata_i;
                    n_wr <= n_wr + 1;
                end
            end
        end
    end
endmodule // alu_mem_model

// ==== bench/logic_shift_bit_alu_assertions.sv ====
// Concurrent checks on the datapath's bus and memory ports
`timescale 1ns/10ps
module logic_shift_bit_alu_assertions #(
    parameter MEM_AW = 32
) (
    input wire              clk_sys_i,
    input wire              rst_i,
    input wire              avs_read_i,
    input wire              avs_waitrequest_o,
    input wire [MEM_AW-1:0] mem_addr_o,
    input wire              mem_read_o,
    input wire              mem_write_o,
    input wire [7:0]        mem_wdata_o,
    input wire              mem_ack_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // Memory read-modify-write steps
    sequence rd_done;
        mem_read_o && mem_ack_i;
    endsequence
    sequence wr_done;
        mem_write_o && mem_ack_i;
    endsequence
    chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    chk_read_answer: assert property (
        avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("read not answered on the next edge");
    chk_reset_idle: assert property ($fell(rst_i) |->
        avs_waitrequest_o && !mem_read_o && !mem_write_o)
        else $error("ports not idle after reset");
    chk_mem_excl: assert property (!(mem_read_o && mem_write_o))
        else $error("memory read and write together");
    chk_rd_hold: assert property (mem_read_o && !mem_ack_i |=>
        mem_read_o && $stable(mem_addr_o))
        else $error("memory read dropped or moved before ack");
    chk_rd_drop: assert property (rd_done |=> !mem_read_o)
        else $error("memory read held after ack");
    chk_wr_hold: assert property (mem_write_o && !mem_ack_i |=>
        mem_write_o && $stable(mem_wdata_o) && $stable(mem_addr_o))
        else $error("memory write changed before ack");
    chk_wr_drop: assert property (wr_done |=> !mem_write_o)
        else $error("memory write held after ack");
    chk_wr_same: assert property ($rose(mem_write_o) |->
        $stable(mem_addr_o))
        else $error("write back to another address");
endmodule // logic_shift_bit_alu_assertions

// ==== bench/test_logic_shift_bit_alu.sv ====
// Self-checking bench for the logic, shift and bit datapath
`timescale 1ns/10ps
`include "lsb_alu_defs.vh"
`define CHK(n, e, a) check(n, e, a)
module test_logic_shift_bit_alu;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [4:0]  avs_address_i = 5'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o, mem_addr_o, rd, st;
    logic        avs_waitrequest_o, mem_read_o, mem_write_o, mem_ack_i;
    logic [7:0]  mem_wdata_o, mem_rdata_i;
    logic [3:0]  lat = 4'h0;
    int          n_errors = 0;
    int          num_checks = 0;
    logic_shift_bit_alu i_logic_shift_bit_alu (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .mem_addr_o(mem_addr_o),
        .mem_read_o(mem_read_o), .mem_write_o(mem_write_o),
        .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
        .mem_ack_i(mem_ack_i));
    alu_mem_model i_alu_mem_model (.clk_sys_i(clk_sys_i),
        .addr_i(mem_addr_o), .rd_i(mem_read_o), .wr_i(mem_write_o),
        .wdata_i(mem_wdata_o), .lat_i(lat), .rdata_o(mem_rdata_i),
        .ack_o(mem_ack_i));
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] e, a);
        num_checks++;
        if (a !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, a);
        end
    endtask
    // ==========================================
    // Avalon master: one request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 64);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (k >= 64) begin
            n_errors++;
            give_verdict;
        end
    endtask
    // Start an operation, wait for done, keep status, clear it
    task automatic run(input logic [31:0] cmd);
        int k;
        bus(1, `OFS_CMD, cmd | 32'h8000_0000);
        k = 0;
        do begin
            bus(0, `OFS_STATUS, 0);
            k++;
        end while (rd[`STS_DONE] !== 1'b1 && k < 64);
        st = rd;
        if (k >= 64) begin
            n_errors++;
            give_verdict;
        end
        bus(1, `OFS_STATUS, 32'h6);
    endtask
    function automatic logic [32:0] exp_alu(input logic [4:0] op,
        input logic [1:0] sz, input logic [31:0] d, s, input logic c);
        logic [31:0] m, v, r, hi;
        logic        msb;
        m = (32'h1 << (sz == 0 ? 8 : sz == 1 ? 16 : 32)) - 1;
        hi = (m >> 1) + 1;
        v = d & m;
        msb = |(v & hi);
        case (op)
            `OP_AND: r = v & s;
            `OP_OR: r = v | s;
            `OP_XOR: r = v ^ s;
            `OP_NOT: r = ~v;
            `OP_ASR: r = (v >> 1) | (v & hi);
            `OP_LSR: r = v >> 1;
            `OP_ROL: r = (v << 1) | msb;
            `OP_ROR: r = (v >> 1) | (v[0] ? hi : 0);
            `OP_ROLC: r = (v << 1) | c;
            `OP_RORC: r = (v >> 1) | (c ? hi : 0);
            default: r = v << 1;
        endcase
        if (op > 3)
            c = op[0] ? v[0] : msb;
        return {c, (d & ~m) | (r & m)};
    endfunction
    function automatic logic [9:0] bitf(input logic [4:0] op,
        input logic [7:0] b, input logic [2:0] n, input logic c, z);
        logic x;
        x = b[n];
        case (op)
            `OP_BFONE: b[n] = 1'b1;
            `OP_BFZERO: b[n] = 1'b0;
            `OP_BTOGGLE: b[n] = ~x;
            `OP_BTEST: z = ~x;
            `OP_CAND: c = c & x;
            `OP_CANDI: c = c & ~x;
            `OP_COR: c = c | x;
            `OP_CORI: c = c | ~x;
            `OP_CXOR: c = c ^ x;
            `OP_CXORI: c = c ^ ~x;
            `OP_BTOC: c = x;
            `OP_IBTOC: c = ~x;
            `OP_CTOB: b[n] = c;
            default: b[n] = ~c;
        endcase
        return {z, c, b};
    endfunction
    // ==========================================
    // Scenarios
    task automatic t_regs;
        bus(0, `OFS_DEST, 0);
        `CHK("dest reset", 0, rd);
        bus(0, 5'h1c, 0);
        `CHK("unmapped read", 0, rd);
        avs_byteenable_i <= 4'h3;
        bus(1, `OFS_DEST, 32'hffff_ffff);
        avs_byteenable_i <= 4'hf;
        bus(0, `OFS_DEST, 0);
        `CHK("dest byteenable", 32'h0000_ffff, rd);
        $display("test regs done");
    endtask
    task automatic t_alu;
        logic [32:0] e;
        logic [31:0] msk;
        for (int op = 0; op < 12; op++) begin
            for (int sz = 0; sz < 3; sz++) begin
                msk = sz == 0 ? 32'hff : sz == 1 ? 32'hffff : 32'hffff_ffff;
                bus(1, `OFS_FLAGS, sz & 1);
                bus(1, `OFS_DEST, 32'h5ac3_f08f);
                bus(1, `OFS_SRC, 32'h0ff0_3c5a);
                run(op | (sz << 5) | (sz[0] << 7));
                e = exp_alu(op, sz, 32'h5ac3_f08f, 32'h0ff0_3c5a, sz[0]);
                bus(0, `OFS_DEST, 0);
                `CHK("alu dest", e[31:0], rd);
                bus(0, `OFS_FLAGS, 0);
                `CHK("alu zero", (e[31:0] & msk) == 0, rd[2]);
                `CHK("alu sign", |(e[31:0] & (msk ^ (msk >> 1))), rd[3]);
                if (op > 3)
                    `CHK("shift carry", e[32], rd[0]);
            end
        end
        $display("test logic and shift done");
    endtask
    task automatic t_bits;
        logic [9:0] e;
        logic [2:0] n;
        for (int op = 12; op < 26; op++) begin
            bus(1, `OFS_FLAGS, op & 5);
            bus(1, `OFS_DEST, 32'h1234_56a5);
            bus(1, `OFS_SRC, 32'hfff8 | (op + 3));
            n = op[0] ? op[2:0] : op[2:0] + 3'h3;
            run(op[0] ? op | (op[2:0] << 9) : op | 32'h100);
            e = bitf(op, 8'ha5, n, op[0], op[2]);
            bus(0, `OFS_DEST, 0);
            `CHK("bit dest", {24'h123456, e[7:0]}, rd);
            bus(0, `OFS_FLAGS, 0);
            `CHK("bit flags", {e[9], 1'b0, e[8]}, rd[2:0]);
        end
        bus(1, `OFS_FLAGS, 0);
        run(`OP_IBTOC | 32'h100);
        `CHK("refused status", 3'b110, st[2:0]);
        bus(0, `OFS_FLAGS, 0);
        `CHK("refused carry", 0, rd[0]);
        $display("test register bits done");
    endtask
    task automatic t_mem(input logic [3:0] l);
        logic [9:0] e;
        logic [7:0] m;
        int         w;
        lat <= l;
        i_alu_mem_model.mem[8'h40] = 8'h3c;
        m = 8'h3c;
        bus(1, `OFS_MEM_ADDR, 32'h40);
        for (int i = 12; i < 26; i++) begin
            bus(1, `OFS_FLAGS, i[1]);
            w = i_alu_mem_model.n_wr;
            run(i | 32'h1000 | (i[2:0] << 9));
            e = bitf(i, m, i[2:0], i[1], 1'b0);
            m = e[7:0];
            `CHK("mem byte", m, i_alu_mem_model.mem[8'h40]);
            `CHK("mem writes", i inside {12, 13, 14, 24, 25}, i_alu_mem_model.n_wr - w);
            bus(0, `OFS_MEM_BYTE, 0);
            `CHK("mem result", m, rd[7:0]);
            bus(0, `OFS_FLAGS, 0);
            `CHK("mem flags", {e[9], 1'b0, e[8]}, rd[2:0]);
        end
        $display("test memory bits done, latency %0d", l);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_regs;
        t_alu;
        t_bits;
        t_mem(4'h0);
        t_mem(4'h3);
        give_verdict;
    end
endmodule // test_logic_shift_bit_alu
bind logic_shift_bit_alu logic_shift_bit_alu_assertions #(.MEM_AW(MEM_AW))
    i_logic_shift_bit_alu_assertions (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .avs_read_i(avs_read_i),
    .avs_waitrequest_o(avs_waitrequest_o), .mem_addr_o(mem_addr_o),
    .mem_read_o(mem_read_o), .mem_write_o(mem_write_o),
    .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i));
